// File: common/dsar_pkg.sv
// shared constants for the display command interpreter and its host
package dsar_pkg;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned ADDR_W      = 7;
	localparam int unsigned CG_ADDR_W   = 6;
	localparam int unsigned DD_DEPTH    = 128;
	localparam int unsigned CG_DEPTH    = 64;
	// command decoding
	localparam logic [3:0] SHIFT_NIB    = 4'h1;
	localparam int unsigned SC_BIT      = 3;
	localparam int unsigned RL_BIT      = 2;
	localparam int unsigned DD_SET_BIT  = 7;
	localparam logic [1:0] CG_SET_TOP   = 2'h1;
	localparam int unsigned BF_BIT      = 7;
	localparam logic [6:0] DD_LAST      = 7'h13;
	localparam logic [7:0] DATA_RESET   = 8'h00;
	localparam logic [6:0] ADDR_RESET   = 7'h00;
	// timing
	localparam int unsigned CLK_NS      = 100;
	localparam int unsigned EXEC_NS     = 1000;
	localparam int unsigned EXEC_CYC    = (EXEC_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned BUSY_W      = $clog2(EXEC_CYC + 1);
	// host register map
	localparam logic [3:0] OFS_OP       = 4'h0;
	localparam logic [3:0] OFS_STAT     = 4'h4;
	localparam int unsigned OP_RS_BIT   = 8;
	localparam int unsigned OP_RD_BIT   = 9;
	localparam int unsigned ST_PEND_BIT = 8;
	localparam int unsigned ST_ERR_BIT  = 9;
	localparam int unsigned ST_STALE_BIT = 10;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;
	localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
	localparam logic [9:0] OP_RESET     = 10'h000;
endpackage : dsar_pkg

// File: common/dsar_bus_if.sv
// parallel host bus between the display controller and its host
`timescale 1ns/10ps
`default_nettype none
interface dsar_bus_if;
	logic       register_select;
	logic       read_sel;
	logic       strobe;
	logic [7:0] host_data;
	logic       host_oe_n;
	logic [7:0] dev_data;
	logic       dev_oe_n;
	logic [7:0] bus;

	// resolved level of the shared data lines, pulled high when idle
	assign bus = !host_oe_n ? host_data : (!dev_oe_n ? dev_data : 8'hff);

	modport dev (
		input  register_select, read_sel, strobe, bus,
		output dev_data, dev_oe_n
	);
	modport host (
		input  bus,
		output register_select, read_sel, strobe, host_data, host_oe_n
	);
endinterface : dsar_bus_if
`default_nettype wire

// File: rtl/dsar_busy_timer.sv
// execution time counter behind the busy indicator
`timescale 1ns/10ps
`default_nettype none
module dsar_busy_timer
	import dsar_pkg::*;
(
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	// control
	input  wire logic start,
	output logic      busy
);
	logic [BUSY_W-1:0] cnt_q;
	logic [BUSY_W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (start) begin
			cnt_d = BUSY_W'(EXEC_CYC);
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - BUSY_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
		end else if (ce) begin
			cnt_q <= cnt_d;
		end
	end

	assign busy = (cnt_q != '0);
endmodule : dsar_busy_timer
`default_nettype wire

// File: rtl/dsar_device.sv
// display controller end: shift, address set, status read, data access
`timescale 1ns/10ps
`default_nettype none
module dsar_device
	import dsar_pkg::*;
(
	// clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                ce,
	// host bus
	dsar_bus_if.dev                  hbus,
	// entry mode and display state
	input  wire logic                step_up,
	output logic [ADDR_W-1:0]        address_counter,
	output logic [ADDR_W-1:0]        display_offset,
	output logic                     glyph_target,
	output logic                     busy_indicator
);
	// counter step by one, wrapping in the seven bit space
	function automatic logic [ADDR_W-1:0] step(
		input logic [ADDR_W-1:0] a,
		input logic              up
	);
		step = up ? a + ADDR_W'(1) : a - ADDR_W'(1);
	endfunction : step

	// kind of bus access seen in this cycle
	typedef enum logic [2:0] {
		DSAR_ACC_NONE  = 3'h0,
		DSAR_ACC_STAT  = 3'h1,
		DSAR_ACC_RFRD  = 3'h2,
		DSAR_ACC_DREAD = 3'h3,
		DSAR_ACC_DWR   = 3'h4,
		DSAR_ACC_INSTR = 3'h5
	} dsar_acc_t;

	// unknown instruction codes only make the device busy
	typedef enum logic [1:0] {
		DSAR_INS_OTHER = 2'h0,
		DSAR_INS_DDSET = 2'h1,
		DSAR_INS_CGSET = 2'h2,
		DSAR_INS_SHIFT = 2'h3
	} dsar_ins_t;

	// refused accesses leave all state alone; a refused read still
	// drives the lines so the host never sees a floating bus
	function automatic dsar_acc_t acc_kind(
		input logic stb,
		input logic rs,
		input logic rd,
		input logic bsy
	);
		if (!stb) begin
			acc_kind = DSAR_ACC_NONE;
		end else if (!rs && rd) begin
			acc_kind = DSAR_ACC_STAT;
		end else if (bsy && rd) begin
			acc_kind = DSAR_ACC_RFRD;
		end else if (bsy) begin
			acc_kind = DSAR_ACC_NONE;
		end else if (rd) begin
			acc_kind = DSAR_ACC_DREAD;
		end else if (rs) begin
			acc_kind = DSAR_ACC_DWR;
		end else begin
			acc_kind = DSAR_ACC_INSTR;
		end
	endfunction : acc_kind

	// address sets are tested first, the shift nibble only below them
	function automatic dsar_ins_t ins_kind(input logic [DATA_W-1:0] b);
		if (b[DD_SET_BIT]) begin
			ins_kind = DSAR_INS_DDSET;
		end else if (b[7:6] == CG_SET_TOP) begin
			ins_kind = DSAR_INS_CGSET;
		end else if (b[7:4] == SHIFT_NIB) begin
			ins_kind = DSAR_INS_SHIFT;
		end else begin
			ins_kind = DSAR_INS_OTHER;
		end
	endfunction : ins_kind

	logic [DATA_W-1:0] dd_mem [DD_DEPTH];
	logic [DATA_W-1:0] cg_mem [CG_DEPTH];

	logic [ADDR_W-1:0] ac_q;
	logic [ADDR_W-1:0] ac_d;
	logic [ADDR_W-1:0] off_q;
	logic [ADDR_W-1:0] off_d;
	logic              cg_q;
	logic              cg_d;
	logic [DATA_W-1:0] dr_q;
	logic [DATA_W-1:0] dr_d;
	logic [DATA_W-1:0] out_q;
	logic [DATA_W-1:0] out_d;
	logic              oe_n_q;
	logic              oe_n_d;

	logic              busy;
	logic              start;
	logic              dd_we;
	logic              cg_we;
	logic [DATA_W-1:0] wbyte;
	logic [DATA_W-1:0] mem_rd;
	dsar_acc_t         acc;
	dsar_ins_t         ins;

	dsar_busy_timer i_dsar_busy_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.start   (start),
		.busy    (busy)
	);

	assign wbyte = hbus.bus;
	// one counter addresses whichever memory was last selected
	assign mem_rd = cg_q ? cg_mem[ac_q[CG_ADDR_W-1:0]] : dd_mem[ac_q];

	// only one strobe per cycle; anything but a status read is refused while busy
	assign acc = acc_kind(hbus.strobe, hbus.register_select, hbus.read_sel,
	                      busy);

	// instruction decode only counts for a taken instruction
	always_comb begin
		ins = DSAR_INS_OTHER;
		if (acc == DSAR_ACC_INSTR) begin
			ins = ins_kind(wbyte);
		end
	end

	always_comb begin
		ac_d   = ac_q;
		off_d  = off_q;
		cg_d   = cg_q;
		dr_d   = dr_q;
		out_d  = out_q;
		oe_n_d = 1'b1;
		start  = 1'b0;
		dd_we  = 1'b0;
		cg_we  = 1'b0;
		unique case (acc)
			DSAR_ACC_NONE: begin
			end
			DSAR_ACC_STAT: begin
				// status read is honoured even while busy
				out_d  = {busy, ac_q};
				oe_n_d = 1'b0;
			end
			DSAR_ACC_RFRD: begin
				// refused read still drives the lines, with old contents
				oe_n_d = 1'b0;
			end
			DSAR_ACC_DREAD: begin
				// the byte on the bus is the one latched by the previous
				// data read, so the first read after an address change is
				// stale and the host end drops it with a dummy read
				out_d  = dr_q;
				dr_d   = mem_rd;
				oe_n_d = 1'b0;
				ac_d   = step(ac_q, step_up);
				start  = 1'b1;
			end
			DSAR_ACC_DWR: begin
				// write leaves the read latch untouched, hence stale reads
				dd_we = !cg_q;
				cg_we = cg_q;
				ac_d  = step(ac_q, step_up);
				start = 1'b1;
			end
			DSAR_ACC_INSTR: begin
				start = 1'b1;
			end
		endcase
		unique case (ins)
			DSAR_INS_OTHER: begin
			end
			DSAR_INS_DDSET: begin
				ac_d = wbyte[ADDR_W-1:0];
				cg_d = 1'b0;
			end
			DSAR_INS_CGSET: begin
				ac_d = {1'b0, wbyte[CG_ADDR_W-1:0]};
				cg_d = 1'b1;
			end
			DSAR_INS_SHIFT: begin
				// cursor always moves; display offset only with bit 3
				ac_d = step(ac_q, wbyte[RL_BIT]);
				cg_d = 1'b0;
				if (wbyte[SC_BIT]) begin
					off_d = step(off_q, wbyte[RL_BIT]);
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ac_q   <= ADDR_RESET;
			off_q  <= ADDR_RESET;
			cg_q   <= 1'b0;
			dr_q   <= DATA_RESET;
			out_q  <= DATA_RESET;
			oe_n_q <= 1'b1;
		end else if (ce) begin
			ac_q   <= ac_d;
			off_q  <= off_d;
			cg_q   <= cg_d;
			dr_q   <= dr_d;
			out_q  <= out_d;
			oe_n_q <= oe_n_d;
		end
	end

	// memories carry no reset; contents are defined by host writes
	always_ff @(posedge aclk) begin
		if (ce && dd_we) begin
			dd_mem[ac_q] <= wbyte;
		end
		if (ce && cg_we) begin
			cg_mem[ac_q[CG_ADDR_W-1:0]] <= wbyte;
		end
	end

	assign hbus.dev_data = out_q;
	assign hbus.dev_oe_n = oe_n_q;
	assign address_counter = ac_q;
	assign display_offset  = off_q;
	assign glyph_target    = cg_q;
	assign busy_indicator  = busy;
endmodule : dsar_device
`default_nettype wire

// File: rtl/dsar_host.sv
// host end: AXI4-Lite registers driving the parallel display bus
`timescale 1ns/10ps
`default_nettype none
module dsar_host
	import dsar_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// axi4-lite write
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// display bus
	dsar_bus_if.host         hbus
);
	typedef enum logic [2:0] {
		DSAR_IDLE  = 3'h0,
		DSAR_POLL  = 3'h1,
		DSAR_PWAIT = 3'h3,
		DSAR_ISSUE = 3'h2,
		DSAR_CAP   = 3'h6
	} dsar_state_t;

	dsar_state_t st_q, st_d;
	logic [9:0]  op_q, op_d;
	logic [7:0]  rd_q, rd_d;
	logic        pend_q, pend_d, err_q, err_d;
	logic        stale_q, stale_d, dummy_q, dummy_d;
	logic        awg_q, awg_d, wg_q, wg_d, bv_q, bv_d, rv_q, rv_d;
	logic [3:0]  aa_q, aa_d;
	logic [9:0]  wd_q, wd_d;
	logic [1:0]  br_q, br_d, rr_q, rr_d;
	logic [31:0] rdat_q, rdat_d;
	logic        op_wr, op_is_rd, op_is_rs;

	assign op_is_rd = op_q[OP_RD_BIT];
	assign op_is_rs = op_q[OP_RS_BIT];
	// strobes are sent only in poll and issue; wstrb is not used
	assign awready = !awg_q && !bv_q;
	assign wready  = !wg_q && !bv_q;
	assign arready = !rv_q;
	assign op_wr   = awg_q && wg_q && (aa_q == OFS_OP) && !pend_q;

	always_comb begin
		awg_d = awg_q; wg_d = wg_q; aa_d = aa_q; wd_d = wd_q;
		bv_d = bv_q; br_d = br_q; rv_d = rv_q; rr_d = rr_q;
		rdat_d = rdat_q;
		if (awvalid && awready) begin
			awg_d = 1'b1;
			aa_d  = awaddr;
		end
		if (wvalid && wready) begin
			wg_d = 1'b1;
			wd_d = wdata[9:0];
		end
		if (awg_q && wg_q) begin
			awg_d = 1'b0;
			wg_d  = 1'b0;
			bv_d  = 1'b1;
			br_d  = (aa_q == OFS_OP || aa_q == OFS_STAT) ? RESP_OKAY
			                                             : RESP_SLVERR;
		end
		if (bv_q && bready) begin
			bv_d = 1'b0;
		end
		if (arvalid && arready) begin
			rv_d   = 1'b1;
			rr_d   = RESP_OKAY;
			rdat_d = WORD_ZERO;
			if (araddr == OFS_OP) begin
				rdat_d[9:0] = op_q;
			end else if (araddr == OFS_STAT) begin
				rdat_d[7:0]          = rd_q;
				rdat_d[ST_PEND_BIT]  = pend_q;
				rdat_d[ST_ERR_BIT]   = err_q;
				rdat_d[ST_STALE_BIT] = stale_q;
			end else begin
				rr_d = RESP_SLVERR;
			end
		end else if (rv_q && rready) begin
			rv_d = 1'b0;
		end
	end

	always_comb begin
		st_d = st_q; op_d = op_q; rd_d = rd_q; pend_d = pend_q;
		err_d = err_q; stale_d = stale_q; dummy_d = dummy_q;
		unique case (st_q)
			DSAR_IDLE: begin
				if (op_wr) begin
					op_d  = wd_q;
					err_d = 1'b0;
					// display address beyond the single line is refused
					if (!wd_q[OP_RS_BIT] && !wd_q[OP_RD_BIT] &&
					    wd_q[DD_SET_BIT] && wd_q[6:0] > DD_LAST) begin
						err_d = 1'b1;
					end else begin
						pend_d  = 1'b1;
						dummy_d = wd_q[OP_RS_BIT] && wd_q[OP_RD_BIT] &&
						          stale_q;
						st_d = (!wd_q[OP_RS_BIT] && wd_q[OP_RD_BIT]) ?
						       DSAR_ISSUE : DSAR_POLL;
					end
				end
			end
			DSAR_POLL:  st_d = DSAR_PWAIT;
			DSAR_PWAIT: begin
				st_d = hbus.bus[BF_BIT] ? DSAR_POLL : DSAR_ISSUE;
			end
			DSAR_ISSUE: st_d = DSAR_CAP;
			DSAR_CAP: begin
				if (op_is_rd && !dummy_q) begin
					rd_d = hbus.bus;
				end
				if (dummy_q) begin
					dummy_d = 1'b0;
					st_d    = DSAR_POLL;
				end else begin
					pend_d = 1'b0;
					st_d   = DSAR_IDLE;
					if (op_is_rs && op_is_rd) begin
						stale_d = 1'b0;
					end else if (!op_is_rd) begin
						stale_d = 1'b1;
					end
				end
			end
		endcase
	end

	always_comb begin
		hbus.strobe          = (st_q == DSAR_POLL) || (st_q == DSAR_ISSUE);
		hbus.register_select = op_is_rs && (st_q == DSAR_ISSUE);
		hbus.read_sel        = (st_q == DSAR_ISSUE) ? (op_is_rd || dummy_q)
		                                            : 1'b1;
		hbus.host_oe_n       = !((st_q == DSAR_ISSUE) && !op_is_rd);
	end
	assign hbus.host_data = op_q[7:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= DSAR_IDLE; op_q <= OP_RESET; rd_q <= DATA_RESET;
			pend_q <= 1'b0; err_q <= 1'b0; stale_q <= 1'b1;
			dummy_q <= 1'b0; awg_q <= 1'b0; wg_q <= 1'b0;
			aa_q <= 4'h0; wd_q <= OP_RESET; bv_q <= 1'b0;
			br_q <= RESP_OKAY; rv_q <= 1'b0; rr_q <= RESP_OKAY;
			rdat_q <= WORD_ZERO;
		end else if (ce) begin
			st_q <= st_d; op_q <= op_d; rd_q <= rd_d;
			pend_q <= pend_d; err_q <= err_d; stale_q <= stale_d;
			dummy_q <= dummy_d; awg_q <= awg_d; wg_q <= wg_d;
			aa_q <= aa_d; wd_q <= wd_d; bv_q <= bv_d;
			br_q <= br_d; rv_q <= rv_d; rr_q <= rr_d;
			rdat_q <= rdat_d;
		end
	end

	assign bvalid = bv_q;
	assign bresp  = br_q;
	assign rvalid = rv_q;
	assign rresp  = rr_q;
	assign rdata  = rdat_q;
endmodule : dsar_host
`default_nettype wire

// File: verif/dsar_props.sv
// checker for the display bus between the host and device ends
`timescale 1ns/10ps
`default_nettype none
module dsar_props
	import dsar_pkg::*;
(
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// display bus
	input  wire logic       register_select,
	input  wire logic       read_sel,
	input  wire logic       strobe,
	input  wire logic [7:0] host_data,
	input  wire logic       host_oe_n,
	input  wire logic [7:0] dev_data,
	input  wire logic       dev_oe_n,
	input  wire logic [7:0] bus
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic       stat_rd;
	assign stat_rd = strobe && !register_select && read_sel;
	// shadow of the execution timer; only idle accesses restart it
	always_comb begin
		cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : cnt_q;
		if (strobe && !stat_rd && cnt_q == 4'h0)
			cnt_d = 4'(EXEC_CYC);
		if (!aresetn)
			cnt_d = 4'h0;
	end
	always_ff @(posedge aclk) begin
		cnt_q <= cnt_d;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_stat_answer;
		stat_rd |=> !dev_oe_n;
	endproperty
	a_stat_answer: assert property (p_stat_answer)
		else $error("status read not answered");
	property p_busy_seen;
		stat_rd |=> dev_data[BF_BIT] == $past(cnt_q != 4'h0);
	endproperty
	a_busy_seen: assert property (p_busy_seen)
		else $error("busy bit wrong in status");
	property p_host_waits;
		strobe && !stat_rd |-> cnt_q == 4'h0;
	endproperty
	a_host_waits: assert property (p_host_waits)
		else $error("access issued while busy");
	property p_read_answer;
		strobe && register_select && read_sel |=> !dev_oe_n;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("data read not answered");
	property p_oe_cause;
		!dev_oe_n |-> $past(strobe && read_sel);
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("device drove bus without a read");
	property p_drive_write;
		strobe && !read_sel |-> !host_oe_n && bus == host_data;
	endproperty
	a_drive_write: assert property (p_drive_write)
		else $error("write byte not on bus");
	property p_dev_hold;
		!(strobe && read_sel) |=> $stable(dev_data);
	endproperty
	a_dev_hold: assert property (p_dev_hold)
		else $error("read latch changed without a read");
	property p_range;
		strobe && !register_select && !read_sel && host_data[DD_SET_BIT]
			|-> host_data[6:0] <= DD_LAST;
	endproperty
	a_range: assert property (p_range)
		else $error("display address out of range");
endmodule : dsar_props
`default_nettype wire

// File: verif/display_shift_addr_rw_cmds_tb.sv
// testbench: host and device ends joined, driven over axi4-lite
`timescale 1ns/10ps
`default_nettype none
module display_shift_addr_rw_cmds_tb
	import dsar_pkg::*;
;
	logic        aclk, aresetn, step_up;
	logic [3:0]  awaddr, araddr, wstrb;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata, st;
	logic [1:0]  bresp, rresp, r;
	logic [6:0]  ac, ofs, e_ac, e_of;
	logic        glyph, busy;
	int          n_errors, comparisons;
	dsar_bus_if  hb ();

	dsar_host i_dsar_host (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.hbus(hb.host));
	dsar_device i_dsar_device (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.hbus(hb.dev), .step_up(step_up), .address_counter(ac),
		.display_offset(ofs), .glyph_target(glyph),
		.busy_indicator(busy));
	dsar_props i_dsar_props (.aclk(aclk), .aresetn(aresetn),
		.register_select(hb.register_select), .read_sel(hb.read_sel),
		.strobe(hb.strobe), .host_data(hb.host_data),
		.host_oe_n(hb.host_oe_n), .dev_data(hb.dev_data),
		.dev_oe_n(hb.dev_oe_n), .bus(hb.bus));

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s exp %h seen %h", nm, e, s);
		end
	endtask : chk

	task axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awready && !aw_ok) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w_ok) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [3:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		st = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// waits for the host to finish; pending is polled, never a fixed delay
	task op(input logic [9:0] c);
		axi_wr(OFS_OP, {22'h0, c});
		st[ST_PEND_BIT] = 1'b1;
		for (int i = 0; i < 100 && st[ST_PEND_BIT] !== 1'b0; i++)
			axi_rd(OFS_STAT);
		chk("op finished", st[ST_PEND_BIT], 32'h0);
	endtask : op

	task t_write_read;
		chk("reset counter", ac, 32'h0);
		chk("reset target", glyph, 32'h0);
		op(10'h085);
		chk("set counter", ac, 32'h5);
		chk("busy after op", busy, 32'h1);
		repeat (EXEC_CYC) @(posedge aclk);
		chk("busy cleared", busy, 32'h0);
		op(10'h1a5);
		chk("step after write", ac, 32'h6);
		op(10'h13c);
		op(10'h200);
		chk("status counter", st[6:0], 32'h7);
		op(10'h085);
		op(10'h300);
		chk("first read", st[7:0], 32'ha5);
		chk("counter after reads", ac, 32'h7);
		op(10'h300);
		chk("second read", st[7:0], 32'h3c);
		chk("stale cleared", st[ST_STALE_BIT], 32'h0);
		@(posedge aclk);
		step_up <= 1'b0;
		op(10'h1ff);
		chk("decrement", ac, 32'h7);
		chk("stale after write", st[ST_STALE_BIT], 32'h1);
		@(posedge aclk);
		step_up <= 1'b1;
	endtask : t_write_read

	task t_shift;
		op(10'h04a);
		op(10'h155);
		op(10'h04a);
		op(10'h300);
		chk("glyph read", st[7:0], 32'h55);
		chk("glyph counter", ac, 32'hc);
		op(10'h04a);
		chk("glyph target", glyph, 32'h1);
		e_ac = 7'h0a;
		e_of = 7'h00;
		for (int i = 0; i < 4; i++) begin
			op({2'b00, 4'h1, i[1:0], 2'b00});
			e_ac = i[0] ? e_ac + 7'h1 : e_ac - 7'h1;
			if (i[1])
				e_of = i[0] ? e_of + 7'h1 : e_of - 7'h1;
			chk("shift counter", ac, {25'h0, e_ac});
			chk("shift offset", ofs, {25'h0, e_of});
		end
		chk("shift target", glyph, 32'h0);
	endtask : t_shift

	task t_errors;
		op(10'h094);
		chk("range error", st[ST_ERR_BIT], 32'h1);
		chk("counter kept", ac, {25'h0, e_ac});
		axi_wr(4'h8, WORD_ZERO);
		chk("bad write", r, {30'h0, RESP_SLVERR});
		axi_rd(4'hc);
		chk("bad read", r, {30'h0, RESP_SLVERR});
		chk("bad read data", st, WORD_ZERO);
	endtask : t_errors

	task print_verdict;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata} = 40'h0;
		wstrb = 4'hf;
		step_up = 1'b1;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_write_read();
		t_shift();
		t_errors();
		print_verdict();
	end

	// a hang is cut short well beyond the few hundred cycles needed
	initial begin
		#3000000;
		n_errors++;
		print_verdict();
	end
endmodule : display_shift_addr_rw_cmds_tb
`default_nettype wire
